// ---- hdl/epg_ctrl.sv ----
// programmer controller driving the eprom pins
`default_nettype none
module epg_ctrl import epg_pkg::*; #(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int SETUP_CYCLES = SETUP_CYC,
    parameter int LAST_ADDR = 16383
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // user side
    input wire logic start_prog,
    input wire logic start_id,
    output logic busy,
    output logic done,
    output logic fail,
    output logic [7:0] id_maker,
    output logic [7:0] id_type,
    output logic [ADDR_W-1:0] fail_addr,
    // source data lookup, same clock, combinational
    output logic [ADDR_W-1:0] src_addr,
    input wire logic [7:0] src_data,
    // device pins
    output logic [ADDR_W-1:0] addr,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic program_strobe_low,
    output logic vpp_raise,
    output logic vcc_raise,
    output logic identifier_high_voltage,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [7:0] data_in
);
    epg_state_t state_reg;
    logic [31:0] tmr_reg;
    logic [4:0] x_reg;
    logic [6:0] over_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] din_s1_reg, din_s2_reg;
    logic readback_reg;

    // pin data passes two flops before compare
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            din_s1_reg <= 8'h00;
            din_s2_reg <= 8'h00;
        end else begin
            din_s1_reg <= data_in;
            din_s2_reg <= din_s1_reg;
        end
    end

    wire logic match = (din_s2_reg == src_data);
    wire logic tmr_done = (tmr_reg == 32'h0);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= EPG_IDLE;
            tmr_reg <= 32'h0;
            x_reg <= 5'h00;
            over_reg <= 7'h00;
            addr_reg <= '0;
            readback_reg <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            fail_addr <= '0;
            id_maker <= 8'h00;
            id_type <= 8'h00;
        end else begin
            if (!tmr_done)
                tmr_reg <= tmr_reg - 32'h1;
            unique case (state_reg)
                EPG_IDLE: begin
                    if (start_prog) begin
                        done <= 1'b0;
                        fail <= 1'b0;
                        addr_reg <= '0;
                        x_reg <= 5'h00;
                        readback_reg <= 1'b0;
                        tmr_reg <= 32'(SETUP_CYCLES);
                        state_reg <= EPG_SETUP;
                    end else if (start_id) begin
                        done <= 1'b0;
                        fail <= 1'b0;
                        tmr_reg <= 32'(SETUP_CYCLES);
                        state_reg <= EPG_ID0;
                    end
                end
                EPG_SETUP: if (tmr_done) begin
                    if (readback_reg) begin
                        tmr_reg <= 32'(SETUP_CYCLES);
                        state_reg <= EPG_READ;
                    end else if (src_data == 8'hFF) begin
                        // erased cells already read ones, nothing to clear
                        state_reg <= EPG_NEXT;
                    end else begin
                        // timer holds one cycle at zero, so load one less for an exact period
                        tmr_reg <= 32'(PULSE_CYCLES - 1); // nominal 1 ms
                        x_reg <= x_reg + 5'h01;
                        state_reg <= EPG_PULSE;
                    end
                end
                EPG_PULSE: if (tmr_done) begin
                    tmr_reg <= 32'(SETUP_CYCLES);
                    state_reg <= EPG_VERIFY;
                end
                EPG_VERIFY: if (tmr_done) begin
                    if (match) begin
                        // overprogram one continuous pulse of 3X ms
                        over_reg <= 7'(OVER_MULT * x_reg);
                        tmr_reg <= 32'(PULSE_CYCLES - 1);
                        state_reg <= EPG_OVER;
                    end else if (x_reg >= 5'(MAX_PULSES)) begin
                        fail <= 1'b1;
                        fail_addr <= addr_reg;
                        state_reg <= EPG_FAIL;
                    end else begin
                        tmr_reg <= 32'(PULSE_CYCLES - 1);
                        x_reg <= x_reg + 5'h01;
                        state_reg <= EPG_PULSE;
                    end
                end
                EPG_OVER: if (tmr_done) begin
                    if (over_reg > 7'h01) begin
                        over_reg <= over_reg - 7'h01;
                        tmr_reg <= 32'(PULSE_CYCLES - 1);
                    end else begin
                        state_reg <= EPG_NEXT;
                    end
                end
                EPG_NEXT: begin
                    x_reg <= 5'h00;
                    tmr_reg <= 32'(SETUP_CYCLES);
                    if (addr_reg == ADDR_W'(LAST_ADDR)) begin
                        addr_reg <= '0;
                        if (readback_reg) begin
                            done <= 1'b1;
                            state_reg <= EPG_DONE;
                        end else begin
                            readback_reg <= 1'b1;
                            state_reg <= EPG_SETUP;
                        end
                    end else begin
                        addr_reg <= addr_reg + ADDR_W'(1);
                        state_reg <= EPG_SETUP;
                    end
                end
                EPG_READ: if (tmr_done) begin
                    if (match) begin
                        state_reg <= EPG_NEXT;
                    end else begin
                        fail <= 1'b1;
                        fail_addr <= addr_reg;
                        state_reg <= EPG_FAIL;
                    end
                end
                EPG_ID0: if (tmr_done) begin
                    id_maker <= din_s2_reg;
                    tmr_reg <= 32'(SETUP_CYCLES);
                    state_reg <= EPG_ID1;
                end
                EPG_ID1: if (tmr_done) begin
                    id_type <= din_s2_reg;
                    // odd parity over all eight bits expected
                    fail <= ~^{id_maker} | ~^din_s2_reg;
                    done <= 1'b1;
                    state_reg <= EPG_DONE;
                end
                EPG_DONE, EPG_FAIL: state_reg <= EPG_IDLE;
                default: state_reg <= EPG_IDLE;
            endcase
        end
    end

    // pin drive registered from a decode of the current state, so the pins lag state_reg by one cycle
    logic pgm_phase, ver_phase, id_phase;
    always_comb begin
        pgm_phase = (state_reg == EPG_PULSE) || (state_reg == EPG_OVER);
        ver_phase = (state_reg == EPG_VERIFY) || (state_reg == EPG_SETUP && !readback_reg);
        id_phase = (state_reg == EPG_ID0) || (state_reg == EPG_ID1);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            addr <= '0;
            src_addr <= '0;
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            program_strobe_low <= 1'b1;
            vpp_raise <= 1'b0;
            vcc_raise <= 1'b0;
            identifier_high_voltage <= 1'b0;
            data_out <= 8'hFF;
            data_oe <= 1'b0;
            busy <= 1'b0;
        end else begin
            busy <= (state_reg != EPG_IDLE) && (state_reg != EPG_DONE) && (state_reg != EPG_FAIL);
            src_addr <= addr_reg;
            // identifier mode: only the two id lines may be high
            addr <= id_phase ? (ID_SEL_MASK | ((state_reg == EPG_ID1) ? ID_BYTE_MASK : '0)) : addr_reg;
            identifier_high_voltage <= id_phase;
            vpp_raise <= !readback_reg && (pgm_phase || ver_phase || state_reg == EPG_NEXT);
            vcc_raise <= !readback_reg && (pgm_phase || ver_phase);
            // select stays low in program/verify so only this part takes pulses
            chip_select_n <= !(pgm_phase || ver_phase || id_phase || state_reg == EPG_READ);
            program_strobe_low <= !pgm_phase;
            output_gate_n <= !(state_reg == EPG_VERIFY || state_reg == EPG_READ || id_phase);
            data_oe <= pgm_phase || (state_reg == EPG_SETUP && !readback_reg);
            data_out <= src_data;
        end
    end

    a_strobe_gate_excl: assert property (@(posedge core_clk) disable iff (!nrst)
        !program_strobe_low |-> output_gate_n && !chip_select_n && data_oe)
        else $error("strobe low while output gate active or bus released");
    a_pulse_count_cap: assert property (@(posedge core_clk) disable iff (!nrst)
        x_reg <= 5'(MAX_PULSES))
        else $error("initial pulse count exceeded limit");
    a_id_addr_low: assert property (@(posedge core_clk) disable iff (!nrst)
        identifier_high_voltage |-> (addr & ~(ID_SEL_MASK | ID_BYTE_MASK)) == '0)
        else $error("address line high in identifier mode");
    a_prog_needs_vpp: assert property (@(posedge core_clk) disable iff (!nrst)
        !program_strobe_low |-> vpp_raise)
        else $error("program strobe without programming supply");
    a_over_len: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg == EPG_VERIFY && tmr_done && match) |=> over_reg == 7'(OVER_MULT * $past(x_reg)))
        else $error("overprogram length not three times count");
    a_x_restart: assert property (@(posedge core_clk) disable iff (!nrst)
        state_reg == EPG_NEXT |=> x_reg == 5'h00)
        else $error("iteration count not cleared on next byte");
    a_prog_vcc_high: assert property (@(posedge core_clk) disable iff (!nrst)
        !program_strobe_low |-> vcc_raise)
        else $error("program strobe without raised core supply");
    a_read_low_supply: assert property (@(posedge core_clk) disable iff (!nrst)
        readback_reg && !output_gate_n |-> !vpp_raise && !vcc_raise)
        else $error("readback done with a raised supply");
endmodule // epg_ctrl
`default_nettype wire

// ---- hdl/epg_pkg.sv ----
// constants for the eprom programmer controller
//
// Contract
// - initial 1 ms pulses, then 3X ms overprogram
// - X counts pulses before first good verify
// - at most 25 initial pulses per byte
// - initial pulse 0.95 to 1.05 ms
// - overprogram pulse 2.85 to 78.75 ms
// - read back all bytes at normal supply
// - low chip select pulse programs one device
// - verify: gate low, select low, strobe high
// - identifier line forced to high voltage
// - other address lines low in identifier mode
// - program mode: supply raised, select and strobe low
`default_nettype none
package epg_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int PULSE_US = 1000;
    localparam int PULSE_CYC = PULSE_US * (CLK_HZ / 1_000_000);
    localparam int SETUP_US = 2;
    localparam int SETUP_CYC = SETUP_US * (CLK_HZ / 1_000_000);
    localparam int MAX_PULSES = 25;
    localparam int OVER_MULT = 3;
    localparam int ADDR_W = 14;
    localparam logic [ADDR_W-1:0] ID_SEL_MASK = 14'h0200;
    localparam logic [ADDR_W-1:0] ID_BYTE_MASK = 14'h0001;
    typedef enum logic [3:0] {
        EPG_IDLE = 4'h0, EPG_SETUP = 4'h1, EPG_PULSE = 4'h3, EPG_VERIFY = 4'h2,
        EPG_OVER = 4'h6, EPG_NEXT = 4'h7, EPG_READ = 4'h5, EPG_DONE = 4'h4,
        EPG_FAIL = 4'hC, EPG_ID0 = 4'hD, EPG_ID1 = 4'hF
    } epg_state_t;
endpackage
`default_nettype wire

// ---- bench/epg_dev_model.sv ----
// behavioural eprom model seen by the programmer controller
`default_nettype none
module epg_dev_model import epg_pkg::*; (
    // pins
    input wire logic core_clk,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic program_strobe_low,
    input wire logic vpp_raise,
    input wire logic identifier_high_voltage,
    input wire logic [7:0] bus_in,
    output logic [7:0] dev_q,
    output logic dev_oe,
    // bench control
    input wire logic erase,
    input wire logic [5:0] need,
    input wire logic bad_par,
    output logic id_addr_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h1C; // arbitrary value, odd parity
    localparam logic [7:0] KIND = 8'h31; // arbitrary value, odd parity
    logic [7:0] mem [4];
    logic [5:0] hits [4];
    logic strobe_q;
    // pulses are counted at their leading edge; a slow cell needs several
    always @(posedge core_clk) begin
        strobe_q <= program_strobe_low;
        if (erase) begin
            id_addr_bad <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                mem[i] <= 8'hFF;
                hits[i] <= 6'h00;
            end
        end else begin
            if (strobe_q && !program_strobe_low && !chip_select_n && vpp_raise) begin
                hits[addr[1:0]] <= hits[addr[1:0]] + 6'h01;
                if (hits[addr[1:0]] + 6'h01 >= need)
                    mem[addr[1:0]] <= mem[addr[1:0]] & bus_in;
            end
            if (identifier_high_voltage && (addr & ~(ID_SEL_MASK | ID_BYTE_MASK)) != '0)
                id_addr_bad <= 1'b1;
        end
    end
    assign dev_oe = !chip_select_n && !output_gate_n && program_strobe_low;
    assign dev_q = !identifier_high_voltage ? mem[addr[1:0]] :
        addr[0] ? KIND : (MAKER ^ {bad_par, 7'h00});
endmodule // epg_dev_model
`default_nettype wire

// ---- bench/epg_ctrl_tb_top.sv ----
// self-checking bench for the eprom programmer controller
`default_nettype none
module epg_ctrl_tb_top;
    import epg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, nrst = 1'b0, start_prog = 1'b0, start_id = 1'b0;
    logic busy, done, fail, chip_select_n, output_gate_n, program_strobe_low;
    logic vpp_raise, vcc_raise, identifier_high_voltage, data_oe, dev_oe, id_addr_bad;
    logic erase = 1'b1, bad_par = 1'b0, flip = 1'b0;
    logic [5:0] need = 6'h02;
    logic [7:0] id_maker, id_type, data_out, data_in, dev_q, src_data;
    logic [ADDR_W-1:0] fail_addr, src_addr, addr;
    logic [7:0] src_tab [4] = '{8'h12, 8'hFF, 8'hA5, 8'h00};
    int failures = 0, num_checks = 0, run_len = 0;
    int widths[$];
    always #10 core_clk = ~core_clk;
    // an idle bus toggles so stale data never passes a verify by luck
    always @(posedge core_clk) flip <= ~flip;
    assign data_in = dev_oe ? dev_q : data_oe ? data_out : {8{flip}};
    assign src_data = src_tab[src_addr[1:0]];
    always @(posedge core_clk) begin
        if (!program_strobe_low) run_len <= run_len + 1;
        else if (run_len != 0) begin
            widths.push_back(run_len);
            run_len <= 0;
        end
    end
    epg_ctrl #(.PULSE_CYCLES(20), .SETUP_CYCLES(6), .LAST_ADDR(3)) DUT (.core_clk(core_clk), .nrst(nrst),
        .start_prog(start_prog), .start_id(start_id), .busy(busy), .done(done), .fail(fail),
        .id_maker(id_maker), .id_type(id_type), .fail_addr(fail_addr), .src_addr(src_addr),
        .src_data(src_data), .addr(addr), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
        .program_strobe_low(program_strobe_low), .vpp_raise(vpp_raise), .vcc_raise(vcc_raise),
        .identifier_high_voltage(identifier_high_voltage), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in));
    epg_dev_model dev (.core_clk(core_clk), .addr(addr), .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .program_strobe_low(program_strobe_low), .vpp_raise(vpp_raise),
        .identifier_high_voltage(identifier_high_voltage), .bus_in(data_in), .dev_q(dev_q),
        .dev_oe(dev_oe), .erase(erase), .need(need), .bad_par(bad_par), .id_addr_bad(id_addr_bad));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic run(input logic prog);
        int n;
        widths.delete();
        @(posedge core_clk);
        erase <= 1'b0;
        start_prog <= prog;
        start_id <= !prog;
        @(posedge core_clk);
        start_prog <= 1'b0;
        start_id <= prog; // refused because state_reg has already left idle, though busy only rises at this same edge
        @(posedge core_clk);
        start_id <= 1'b0;
        #1;
        check(busy, 1'b1);
        n = 0;
        while (done !== 1'b1 && fail !== 1'b1 && n < 20000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (done !== 1'b1 && fail !== 1'b1) begin
            failures++;
            end_of_test();
        end
        @(posedge core_clk);
        #1;
        check(busy, 1'b0);
    endtask
    task automatic t_ident(input logic bad);
        bad_par <= bad;
        run(1'b0);
        check(fail, bad);
        check(id_addr_bad, 1'b0);
        if (!bad) begin
            check(id_maker, 8'h1C);
            check(id_type, 8'h31);
        end
    endtask
    task automatic t_fail();
        @(posedge core_clk);
        erase <= 1'b1;
        need <= 6'h1A;
        run(1'b1);
        check(fail, 1'b1);
        check(fail_addr, 0);
        check(widths.size(), MAX_PULSES);
        check(widths[0], 20);
    endtask
    // x is the pulse count each non-FF byte needs before a good verify
    task automatic t_prog(input int x, input logic wipe);
        @(posedge core_clk);
        erase <= wipe;
        need <= 6'h02;
        run(1'b1);
        check(done, 1'b1);
        check(fail, 1'b0);
        for (int i = 0; i < 4; i++) check(dev.mem[i], src_tab[i]);
        check(widths.size(), 3 * (x + 1));
        for (int i = 0; i < widths.size(); i++)
            check(widths[i], (i % (x + 1) == x) ? 60 * x : 20);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        check({chip_select_n, program_strobe_low, vpp_raise, data_oe}, 4'hC);
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        t_ident(1'b0);
        t_ident(1'b1);
        t_fail();
        t_prog(2, 1'b1);
        t_prog(1, 1'b0);
        end_of_test();
    end
endmodule // epg_ctrl_tb_top
`default_nettype wire
